// ### pkg/sdpd_consts.svh
// constants for the sdram power-down control block
// assumes cycle counts are in link clock cycles (nCK)
`ifndef SDPD_CONSTS_SVH
`define SDPD_CONSTS_SVH

`define SDPD_CNT_W      8
`define SDPD_CNT_ZERO   8'h00
`define SDPD_CNT_ONE    8'h01
// entry guard, exit latencies, in nCK; plain defaults, tune per speed bin
`define SDPD_TCPDED_NCK 8'h02
`define SDPD_TXP_NCK    8'h04
`define SDPD_TXPDLL_NCK 8'h0a
`define SDPD_STAT_W     4
`define SDPD_STAT_RST   4'h0
`define SDPD_OUT_W      3
`define SDPD_OUT_RST    3'h0
// bit positions of the status word sent to the system domain
`define SDPD_OUT_ACT    2
`define SDPD_OUT_PRE    1
`define SDPD_OUT_DLL    0

`endif

// ### pkg/sdpd_pkg.sv
// types shared by the sdram power-down control block
// assumes the constants header is on the include path
package sdpd_pkg;

	// command bus as sampled on the link clock
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} sdpd_cmd_t;

	// status levels passed from the system domain to the link domain
	typedef struct packed {
		logic bank_open;
		logic op_busy;
		logic precharge_pd_dll_bit;
		logic dll_locked;
	} sdpd_stat_t;

	typedef enum logic [1:0] {
		SDPD_RUN,
		SDPD_ENTRY,
		SDPD_PD,
		SDPD_EXIT
	} sdpd_state_t;

endpackage : sdpd_pkg

// ### core/sdpd_ctrl.sv
// power-down entry and exit control of the sdram device core
// assumes command pins are synchronous to ck_i; status comes from sys_clk_i logic
`timescale 1ns/10ps
`include "sdpd_consts.svh"

module sdpd_ctrl
	import sdpd_pkg::*;
(
	// system domain
	input  wire logic       sys_clk_i,
	input  wire logic       sys_rst_i,
	input  wire sdpd_stat_t stat_i,
	output logic            pd_active_o,
	output logic            pd_precharge_o,
	output logic            dll_reset_req_o,
	// link domain pins
	input  wire logic       ck_i,
	input  wire logic       reset_n_i,
	input  wire logic       cke_i,
	input  wire sdpd_cmd_t  cmd_i,
	// link domain controls to the device core
	output logic            cmd_rcv_en_o,
	output logic            io_buf_en_o,
	output logic            dll_run_o,
	output logic            cmd_ok_o,
	output logic            dll_cmd_ok_o
);

	function automatic logic [`SDPD_CNT_W-1:0] dec_sat(input logic [`SDPD_CNT_W-1:0] v);
		dec_sat = (v == `SDPD_CNT_ZERO) ? `SDPD_CNT_ZERO : v - `SDPD_CNT_ONE;
	endfunction : dec_sat

	// link domain reset: pin or system reset, synchronised to ck
	logic                    rst_meta_reg;
	logic                    ck_rst_reg;
	logic                    rst_req;
	sdpd_stat_t              stat_meta_reg;
	sdpd_stat_t              stat_s_reg;
	sdpd_state_t             state_reg;
	sdpd_state_t             state_next;
	logic [`SDPD_CNT_W-1:0]  cnt_reg;
	logic [`SDPD_CNT_W-1:0]  cnt_next;
	logic [`SDPD_CNT_W-1:0]  dll_cnt_reg;
	logic [`SDPD_CNT_W-1:0]  dll_cnt_next;
	logic                    cke_prev_reg;
	logic                    prech_reg;
	logic                    prech_next;
	logic                    settled_reg;
	logic                    settled_next;
	logic                    dll_keep_reg;
	logic                    dll_keep_next;
	logic                    slow_exit_reg;
	logic                    dll_req_reg;
	logic                    dll_req_next;

	// the reset pin is gated before the first flop only
	assign rst_req = sys_rst_i | ~reset_n_i;

	always_ff @(posedge ck_i) begin
		rst_meta_reg <= rst_req;
		ck_rst_reg   <= rst_meta_reg;
	end

	always_ff @(posedge ck_i) begin
		if (ck_rst_reg) begin
			stat_meta_reg <= `SDPD_STAT_RST;
			stat_s_reg    <= `SDPD_STAT_RST;
		end else begin
			stat_meta_reg <= stat_i;
			stat_s_reg    <= stat_meta_reg;
		end
	end

	// command decode
	wire cmd_nop  = cmd_i.cs_n | (cmd_i.ras_n & cmd_i.cas_n & cmd_i.we_n);
	wire cmd_mrs  = ~cmd_i.cs_n & ~cmd_i.ras_n & ~cmd_i.cas_n & ~cmd_i.we_n;
	wire in_run   = (state_reg == SDPD_RUN);
	wire in_entry = (state_reg == SDPD_ENTRY);
	wire in_pd    = (state_reg == SDPD_PD);
	wire in_exit  = (state_reg == SDPD_EXIT);
	wire low_side = in_entry | in_pd;
	wire entry_ev = in_run & cke_prev_reg & ~cke_i & cmd_nop;
	wire exit_ev  = in_pd & cke_i & cmd_nop;
	// mode settles once running operations end
	wire settle   = low_side & ~stat_s_reg.op_busy;
	wire dll_stop = settled_reg & prech_reg & ~dll_keep_reg & low_side;

	always_comb begin
		state_next    = state_reg;
		cnt_next      = dec_sat(cnt_reg);
		dll_cnt_next  = dec_sat(dll_cnt_reg);
		prech_next    = prech_reg;
		settled_next  = settled_reg;
		dll_keep_next = dll_keep_reg;
		dll_req_next  = dll_req_reg;
		unique case (state_reg)
			SDPD_RUN: begin
				settled_next = 1'b0;
				if (cmd_mrs) begin
					dll_req_next = 1'b0;
				end
				if (entry_ev) begin
					state_next    = SDPD_ENTRY;
					cnt_next      = `SDPD_TCPDED_NCK;
					dll_keep_next = stat_s_reg.precharge_pd_dll_bit;
					prech_next    = 1'b0;
					// unlocked entry needs a later DLL reset
					if (!stat_s_reg.dll_locked) begin
						dll_req_next = 1'b1;
					end
				end
			end
			SDPD_ENTRY: begin
				if (cnt_reg == `SDPD_CNT_ZERO) begin
					state_next = SDPD_PD;
				end
			end
			SDPD_PD: begin
				if (exit_ev) begin
					state_next   = SDPD_EXIT;
					cnt_next     = `SDPD_TXP_NCK;
					// slow exit waits tXPDLL for DLL commands
					dll_cnt_next = dll_stop ? `SDPD_TXPDLL_NCK : `SDPD_TXP_NCK;
				end
			end
			SDPD_EXIT: begin
				if (cnt_reg == `SDPD_CNT_ZERO && dll_cnt_reg == `SDPD_CNT_ZERO) begin
					state_next = SDPD_RUN;
				end
			end
		endcase
		// precharge or active mode chosen after settling
		if (settle && !settled_reg) begin
			settled_next = 1'b1;
			prech_next   = ~stat_s_reg.bank_open;
		end
	end

	always_ff @(posedge ck_i) begin
		if (ck_rst_reg) begin
			state_reg     <= SDPD_RUN;
			cnt_reg       <= `SDPD_CNT_ZERO;
			dll_cnt_reg   <= `SDPD_CNT_ZERO;
			cke_prev_reg  <= 1'b0;
			prech_reg     <= 1'b0;
			settled_reg   <= 1'b0;
			dll_keep_reg  <= 1'b0;
			slow_exit_reg <= 1'b0;
			dll_req_reg   <= 1'b0;
		end else begin
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			dll_cnt_reg   <= dll_cnt_next;
			cke_prev_reg  <= cke_i;
			prech_reg     <= prech_next;
			settled_reg   <= settled_next;
			dll_keep_reg  <= dll_keep_next;
			slow_exit_reg <= exit_ev ? dll_stop : slow_exit_reg;
			dll_req_reg   <= dll_req_next;
		end
	end

	// only clock, CKE, ODT and reset stay alive in power-down
	assign cmd_rcv_en_o = ~in_pd;
	assign io_buf_en_o  = in_run | in_exit;
	// active power-down never stops the DLL
	// DLL bit set keeps the DLL in precharge power-down
	assign dll_run_o    = ~dll_stop & ~(in_pd & settled_reg & prech_reg & ~dll_keep_reg);
	// exit latency gates; dll counter covers tXPDLL on slow exit
	assign cmd_ok_o     = in_run | (in_exit & (cnt_reg == `SDPD_CNT_ZERO));
	assign dll_cmd_ok_o = in_run | (in_exit & (dll_cnt_reg == `SDPD_CNT_ZERO));

	// status back to the system domain, levels only, two flops each
	logic [`SDPD_OUT_W-1:0] out_meta_reg;
	logic [`SDPD_OUT_W-1:0] out_s_reg;
	wire  [`SDPD_OUT_W-1:0] out_src = {~in_run, prech_reg & settled_reg, dll_req_reg};

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			out_meta_reg <= `SDPD_OUT_RST;
			out_s_reg    <= `SDPD_OUT_RST;
		end else begin
			out_meta_reg <= out_src;
			out_s_reg    <= out_meta_reg;
		end
	end

	// outputs lag the link state by two system clocks
	assign pd_active_o     = out_s_reg[`SDPD_OUT_ACT];
	assign pd_precharge_o  = out_s_reg[`SDPD_OUT_PRE];
	assign dll_reset_req_o = out_s_reg[`SDPD_OUT_DLL];

	default clocking cb @(posedge ck_i); endclocking
	default disable iff (ck_rst_reg);

	a_entry_on_cke: assert property (
		entry_ev |=> in_entry)
		else $error("cke low with nop did not start entry");

	a_busy_keeps_dll: assert property (
		(in_pd && stat_s_reg.op_busy && !settled_reg) |-> dll_run_o)
		else $error("dll stopped before operations finished");

	a_mode_from_banks: assert property (
		(low_side && !stat_s_reg.op_busy && !settled_reg) |=> (prech_reg == !$past(stat_s_reg.bank_open)))
		else $error("power-down mode does not match bank state");

	a_buffers_off: assert property (
		(in_pd && !$past(in_pd)) |-> (!io_buf_en_o && $past(in_entry)))
		else $error("buffers not off on power-down");

	a_tcpded_guard: assert property (
		entry_ev |=> cmd_rcv_en_o [*3] ##1 !cmd_rcv_en_o)
		else $error("receivers not held for tcpded");

	a_active_dll_on: assert property (
		(in_pd && settled_reg && !prech_reg) |-> dll_run_o)
		else $error("dll stopped in active power-down");

	a_prech_dll_bit: assert property (
		(in_pd && settled_reg && prech_reg) |-> (dll_run_o == dll_keep_reg))
		else $error("dll state differs from dll bit");

	a_slow_exit_wait: assert property (
		(exit_ev && dll_stop) |=> (cmd_ok_o == 1'b0) [*4] ##1 (cmd_ok_o && !dll_cmd_ok_o))
		else $error("slow exit latencies wrong");

	a_exit_txp: assert property (
		exit_ev |=> (in_exit && !cmd_ok_o) [*4] ##1 cmd_ok_o)
		else $error("exit latency txp wrong");

	a_dll_req_set: assert property (
		(entry_ev && !stat_s_reg.dll_locked) |=> dll_req_reg)
		else $error("dll reset demand not raised");

	a_reset_leaves: assert property (@(posedge ck_i) disable iff (1'b0)
		ck_rst_reg |=> in_run)
		else $error("reset did not leave power-down");

	a_entry_needs_nop: assert property (
		(in_run && !cmd_nop) |=> !in_entry)
		else $error("entry taken without nop");

	a_run_while_high: assert property (
		(in_run && cke_i) |=> in_run)
		else $error("left run with cke high");

	a_settle_waits: assert property (
		(low_side && stat_s_reg.op_busy && !settled_reg) |=> !settled_reg)
		else $error("mode settled while operations ran");

	a_io_off_entry: assert property (
		entry_ev |=> (!io_buf_en_o && cmd_rcv_en_o))
		else $error("receivers dropped at entry");

	a_active_fast: assert property (
		(exit_ev && settled_reg && !prech_reg) |=> !slow_exit_reg)
		else $error("active power-down took slow exit");

	a_exit_to_run: assert property (
		(in_exit && cmd_ok_o && dll_cmd_ok_o) |=> in_run)
		else $error("exit did not return to run");

	a_slow_txpdll: assert property (
		(exit_ev && dll_stop) |-> ##10 !dll_cmd_ok_o ##1 dll_cmd_ok_o)
		else $error("slow exit txpdll wrong");

	a_dll_bit_latch: assert property (
		entry_ev |=> (dll_keep_reg == $past(stat_s_reg.precharge_pd_dll_bit)))
		else $error("dll bit not latched at entry");

	a_fast_exit_same: assert property (
		(in_exit && !slow_exit_reg) |-> (dll_cmd_ok_o == cmd_ok_o))
		else $error("fast exit gates differ");

	a_stay_in_pd: assert property (
		(in_pd && !(cke_i && cmd_nop)) |=> in_pd)
		else $error("left power-down without exit");

	a_exit_on_cke: assert property (
		exit_ev |=> (in_exit && cmd_rcv_en_o && io_buf_en_o))
		else $error("exit did not restore buffers");

endmodule : sdpd_ctrl

// ### testbench/sdpd_ctl_model.sv
// memory controller model: drives cke and commands on the link clock
// assumes the bench asks for entry, exit and mode register set by levels
`timescale 1ns/10ps
module sdpd_ctl_model
	import sdpd_pkg::*;
#(
	parameter int TCKE   = 3,
	parameter int TXPDLL = 10
) (
	// link clock and requests
	input  wire logic ck_i,
	input  wire logic pd_req_i,
	input  wire logic mrs_req_i,
	// pins to the device
	output logic      cke_o,
	output sdpd_cmd_t cmd_o
);
	int hold_cnt = 0;
	initial begin
		cke_o = 1'b1;
		cmd_o = 4'hf;
	end
	// high for txpdll after exit; no refresh is ever issued
	// never lowers cke while a mode register set is pending
	always @(posedge ck_i) begin
		if (hold_cnt > 0) begin
			hold_cnt <= hold_cnt - 1;
		end else if (cke_o == pd_req_i && !(pd_req_i && mrs_req_i)) begin
			cke_o    <= !pd_req_i;
			hold_cnt <= pd_req_i ? TCKE : TXPDLL;
		end
		cmd_o <= (mrs_req_i && cke_o && !pd_req_i) ? 4'h0 : 4'hf;
	end
endmodule : sdpd_ctl_model

// ### testbench/tb_sdram_power_down_control.sv
// self-checking bench of the power-down control block
// assumes the controller model keeps cke and command rules
`timescale 1ns/10ps
`include "sdpd_consts.svh"
module tb_sdram_power_down_control
	import sdpd_pkg::*;
;
	localparam int TCPDED = `SDPD_TCPDED_NCK;
	localparam int TXP    = `SDPD_TXP_NCK;
	localparam int TXPDLL = `SDPD_TXPDLL_NCK;
	logic       sys_clk_i = 0, sys_rst_i = 1, ck_i = 0, reset_n_i = 1;
	logic       pd_req = 0, mrs_req = 0, cke;
	sdpd_stat_t stat_i = '0;
	sdpd_cmd_t  cmd;
	logic       pd_act, pd_pre, dll_req, rcv_en, io_en, dll_run, ok, dll_ok;
	int         error_cnt = 0, n_tests = 0;
	initial forever #10 sys_clk_i = !sys_clk_i;
	initial forever #7.5 ck_i = !ck_i;
	sdpd_ctl_model #(.TXPDLL(TXPDLL)) model (.ck_i(ck_i), .pd_req_i(pd_req), .mrs_req_i(mrs_req),
		.cke_o(cke), .cmd_o(cmd));
	sdpd_ctrl dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .stat_i(stat_i),
		.pd_active_o(pd_act), .pd_precharge_o(pd_pre), .dll_reset_req_o(dll_req),
		.ck_i(ck_i), .reset_n_i(reset_n_i), .cke_i(cke), .cmd_i(cmd),
		.cmd_rcv_en_o(rcv_en), .io_buf_en_o(io_en), .dll_run_o(dll_run),
		.cmd_ok_o(ok), .dll_cmd_ok_o(dll_ok));
	task chk(input string name, input logic seen, input logic exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %b seen %b", name, exp, seen);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge ck_i);
		#1;
	endtask : tick
	task end_sim;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task test_reset;
		chk("rcv_en", rcv_en, 1'b1);
		chk("io_en", io_en, 1'b1);
		chk("dll_run", dll_run, 1'b1);
		chk("cmd_ok", ok, 1'b1);
		chk("pd_act", pd_act, 1'b0);
		$display("test_reset done");
	endtask : test_reset
	task test_mode(input logic open, input logic dbit, input logic lck, input logic slow);
		@(posedge sys_clk_i) stat_i <= '{open, 1'b1, dbit, lck};
		tick(6);
		@(posedge ck_i) pd_req <= 1'b1;
		tick(2);
		chk("io_en", io_en, 1'b0);
		tick(TCPDED);
		chk("rcv_en", rcv_en, 1'b1);
		tick(1);
		chk("rcv_en", rcv_en, 1'b0);
		tick(6);
		chk("dll_run", dll_run, 1'b1);
		@(posedge sys_clk_i) stat_i.op_busy <= 1'b0;
		// stay is tens of cycles, far below nine refresh intervals
		tick(14);
		chk("dll_run", dll_run, !slow);
		chk("pd_pre", pd_pre, !open);
		chk("pd_act", pd_act, 1'b1);
		chk("dll_req", dll_req, !lck);
		@(posedge ck_i) pd_req <= 1'b0;
		tick(2);
		chk("rcv_en", rcv_en, 1'b1);
		chk("dll_run", dll_run, 1'b1);
		tick(TXP - 1);
		chk("cmd_ok", ok, 1'b0);
		tick(1);
		chk("cmd_ok", ok, 1'b1);
		chk("dll_ok", dll_ok, !slow);
		if (slow) begin
			tick(TXPDLL - TXP - 1);
			chk("dll_ok", dll_ok, 1'b0);
			tick(1);
			chk("dll_ok", dll_ok, 1'b1);
		end
		tick(4);
		// dll reset by mode register set, after the exit latency
		@(posedge ck_i) mrs_req <= 1'b1;
		@(posedge ck_i) mrs_req <= 1'b0;
		tick(10);
		chk("dll_req", dll_req, 1'b0);
		chk("pd_act", pd_act, 1'b0);
		$display("test_mode done");
	endtask : test_mode
	task test_pd_reset;
		@(posedge ck_i) pd_req <= 1'b1;
		tick(12);
		chk("rcv_en", rcv_en, 1'b0);
		@(posedge ck_i) reset_n_i <= 1'b0;
		tick(5);
		chk("rcv_en", rcv_en, 1'b1);
		chk("io_en", io_en, 1'b1);
		chk("cmd_ok", ok, 1'b1);
		@(posedge ck_i) reset_n_i <= 1'b1;
		pd_req <= 1'b0;
		tick(10);
		chk("pd_act", pd_act, 1'b0);
		$display("test_pd_reset done");
	endtask : test_pd_reset
	initial begin
		repeat (5) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		tick(10);
		test_reset();
		test_mode(1'b1, 1'b0, 1'b1, 1'b0);
		test_mode(1'b0, 1'b0, 1'b1, 1'b1);
		test_mode(1'b0, 1'b1, 1'b1, 1'b0);
		test_mode(1'b0, 1'b1, 1'b0, 1'b0);
		test_pd_reset();
		end_sim();
	end
	// whole run is a few hundred link cycles
	initial begin
		#50000;
		error_cnt++;
		end_sim();
	end
endmodule : tb_sdram_power_down_control
